/* File: lpm_rst_map.svh */
/*
  Constants for the low-power mode and reset controller.
  Assumes inclusion by bare name from lpm_rst_pkg.sv and the controller.
*/
`ifndef LPM_RST_MAP_SVH
`define LPM_RST_MAP_SVH

// ----------------------------------------------------------------------------
// Boot pin encodings
// ----------------------------------------------------------------------------
`define BOOT_PIN_FLASH     2'h0
`define BOOT_PIN_SYSMEM    2'h1
`define BOOT_PIN_SRAM      2'h3

// ----------------------------------------------------------------------------
// Clock source encodings
// ----------------------------------------------------------------------------
`define CLK_SRC_FAST_RC    2'h0
`define CLK_SRC_CRYSTAL    2'h1
`define CLK_SRC_PLL        2'h2

// ----------------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------------
`define PIN_LINE_COUNT     16
`define RST_STRETCH_CYC    4

`endif

/* File: lpm_rst_pkg.sv */
/*
  Types shared by the low-power mode and reset controller.
  Assumes the map header is on the include path.
*/
package lpm_rst_pkg;
  `include "lpm_rst_map.svh"

  typedef enum logic [1:0] {
    BOOT_FLASH,
    BOOT_SYSMEM,
    BOOT_SRAM
  } boot_src_t;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_SLEEP,
    PM_DEEP,
    PM_STANDBY
  } pm_state_t;
endpackage

/* File: lpm_rst_ctrl.sv */
/*
  Power mode sequencer, reset generator and boot source latch.
  Assumes synchronous single-bit inputs on CLK_I from the core, the event
  lines, the supply supervisor, the watchdog and the pins.
*/
// Functional notes
// R01: Sleep gates only core clock; peripherals run; any interrupt or event wakes.
// R02: Deep-sleep stops core domain clocks, fast RC, crystal, PLL; retains state.
// R03: Deep-sleep exits on any interrupt or external event line wake source.
// R04: Every deep-sleep exit selects the internal fast RC as system clock.
// R05: Standby powers off core domain and regulator, oscillators and PLL off.
// R06: Standby wakes only on reset pin, RTC alarm, watchdog, wake pin rise.
// R07: Three resets: power, system, backup; system spares debug and backup.
// R08: Supply supervision always on; held in reset while supply is low.
// R09: Low-voltage detector crossing raises a warning interrupt.
// R10: Boot pins choose flash (default), system memory or SRAM.
// R11: Boot pins sampled once at reset release; held until next reset.
`timescale 1ns/100ps
`include "lpm_rst_map.svh"

module lpm_rst_ctrl
  import lpm_rst_pkg::*;
#(
  parameter int LINES   = `PIN_LINE_COUNT,
  parameter int STRETCH = `RST_STRETCH_CYC
) (
  input  wire logic             CLK_I,
  input  wire logic             RST_I,
  input  wire logic             SLEEP_REQ_I,
  input  wire logic             DEEP_REQ_I,
  input  wire logic             STANDBY_REQ_I,
  input  wire logic [1:0]       CLK_SEL_I,
  input  wire logic             IRQ_PENDING_I,
  input  wire logic             EVENT_I,
  input  wire logic [LINES-1:0] PIN_LINES_I,
  input  wire logic             RTC_ALARM_I,
  input  wire logic             RTC_TAMPER_I,
  input  wire logic             SERIAL_WAKE_I,
  input  wire logic             CEC_WAKE_I,
  input  wire logic             LVD_OUT_I,
  input  wire logic             SUPPLY_LOW_I,
  input  wire logic             EXT_RESET_PIN_I,
  input  wire logic             WATCHDOG_RST_I,
  input  wire logic             WAKE_PIN_I,
  input  wire logic             BACKUP_RST_REQ_I,
  input  wire logic             SW_RST_REQ_I,
  input  wire logic [1:0]       BOOT_PINS_I,
  output logic                  CORE_CLK_EN_O,
  output logic                  PERIPH_CLK_EN_O,
  output logic                  FAST_RC_EN_O,
  output logic                  CRYSTAL_EN_O,
  output logic                  PLL_EN_O,
  output logic [1:0]            SYS_CLK_SRC_O,
  output logic                  CORE_PWR_EN_O,
  output logic                  REGULATOR_EN_O,
  output logic                  RETAIN_O,
  output logic                  POWER_RST_O,
  output logic                  SYSTEM_RST_O,
  output logic                  BACKUP_RST_O,
  output logic                  LVD_IRQ_O,
  output logic [1:0]            BOOT_SRC_O,
  output logic [1:0]            PM_STATE_O
);

  initial begin
    if (LINES < 1 || STRETCH < 1 || STRETCH > 255) begin
      $error("lpm_rst_ctrl: bad parameter");
    end
  end

  // --------------------------------------------------------------------------
  // Wake decode
  // --------------------------------------------------------------------------
  pm_state_t  state_ff;
  pm_state_t  nxt_state;
  logic       wake_pin_ff;
  logic       lvd_ff;
  logic [7:0] stretch_ff;
  logic       boot_done_ff;

  // R01 sleep wake
  wire sleep_wake = IRQ_PENDING_I | EVENT_I;
  // R03 deep-sleep wake
  wire deep_wake  = IRQ_PENDING_I | (|PIN_LINES_I) | RTC_ALARM_I | LVD_OUT_I |
                    RTC_TAMPER_I | SERIAL_WAKE_I | CEC_WAKE_I;
  wire wake_rise  = WAKE_PIN_I & ~wake_pin_ff;
  // R06 four standby sources
  wire stby_wake  = EXT_RESET_PIN_I | RTC_ALARM_I | WATCHDOG_RST_I | wake_rise;
  wire lvd_rise   = LVD_OUT_I & ~lvd_ff;

  // R08 supply supervisor always active, forces power reset
  wire power_rst  = RST_I | SUPPLY_LOW_I;
  wire sys_cause  = EXT_RESET_PIN_I | WATCHDOG_RST_I | SW_RST_REQ_I;
  // Standby wake restarts a powered-down core, so it must start under reset
  wire sys_start  = sys_cause | (state_ff == PM_STANDBY && stby_wake);

  function automatic logic [1:0] boot_decode(input logic [1:0] pins);
    case (pins)
      `BOOT_PIN_SYSMEM: boot_decode = BOOT_SYSMEM;
      `BOOT_PIN_SRAM:   boot_decode = BOOT_SRAM;
      default:          boot_decode = BOOT_FLASH;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Mode sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PM_RUN: begin
        if (STANDBY_REQ_I) begin
          nxt_state = PM_STANDBY;
        end else if (DEEP_REQ_I) begin
          nxt_state = PM_DEEP;
        end else if (SLEEP_REQ_I) begin
          nxt_state = PM_SLEEP;
        end
      end
      PM_SLEEP:   if (sleep_wake) nxt_state = PM_RUN;
      PM_DEEP:    if (deep_wake) nxt_state = PM_RUN;
      // Standby exit goes through a system reset
      PM_STANDBY: if (stby_wake) nxt_state = PM_RUN;
      default:    nxt_state = PM_RUN;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (power_rst) begin
      state_ff <= PM_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------------
  // Clock source: fast RC on power reset and after every deep-sleep exit
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (power_rst) begin
      SYS_CLK_SRC_O <= `CLK_SRC_FAST_RC;
    // R04 force fast RC on deep exit
    end else if (state_ff == PM_DEEP && deep_wake) begin
      SYS_CLK_SRC_O <= `CLK_SRC_FAST_RC;
    end else if (state_ff == PM_RUN && nxt_state == PM_RUN) begin
      SYS_CLK_SRC_O <= CLK_SEL_I;
    end
  end

  // --------------------------------------------------------------------------
  // Clock and power enables
  // --------------------------------------------------------------------------
  // R01 sleep gates core clock only
  wire core_clk  = (nxt_state == PM_RUN);
  // R02 deep-sleep and standby stop domain clocks
  wire dom_on    = (nxt_state == PM_RUN) || (nxt_state == PM_SLEEP);
  // R05 standby removes power
  wire pwr_on    = (nxt_state != PM_STANDBY);
  wire sel_xtal  = (CLK_SEL_I == `CLK_SRC_CRYSTAL);
  wire sel_pll   = (CLK_SEL_I == `CLK_SRC_PLL);

  always_ff @(posedge CLK_I) begin
    if (power_rst) begin
      CORE_CLK_EN_O   <= 1'b1;
      PERIPH_CLK_EN_O <= 1'b1;
      FAST_RC_EN_O    <= 1'b1;
      CRYSTAL_EN_O    <= 1'b0;
      PLL_EN_O        <= 1'b0;
      CORE_PWR_EN_O   <= 1'b1;
      REGULATOR_EN_O  <= 1'b1;
      RETAIN_O        <= 1'b0;
    end else begin
      CORE_CLK_EN_O   <= core_clk;
      PERIPH_CLK_EN_O <= dom_on;
      // R02 oscillators off outside run and sleep
      FAST_RC_EN_O    <= dom_on;
      CRYSTAL_EN_O    <= dom_on & sel_xtal & ~(state_ff == PM_DEEP);
      PLL_EN_O        <= dom_on & sel_pll & ~(state_ff == PM_DEEP);
      CORE_PWR_EN_O   <= pwr_on;
      REGULATOR_EN_O  <= pwr_on;
      // R02 retention in deep-sleep
      RETAIN_O        <= (nxt_state == PM_DEEP);
    end
  end

  // --------------------------------------------------------------------------
  // Resets
  // --------------------------------------------------------------------------
  // Stretch keeps the system reset visible for a fixed minimum width
  always_ff @(posedge CLK_I) begin
    if (power_rst) begin
      stretch_ff <= 8'(STRETCH);
    // R07 system reset on pin, watchdog, software, standby exit
    end else if (sys_start) begin
      stretch_ff <= 8'(STRETCH);
    end else if (stretch_ff != 8'h00) begin
      stretch_ff <= stretch_ff - 8'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    wake_pin_ff  <= WAKE_PIN_I;
    lvd_ff       <= LVD_OUT_I;
    // R08 reset held while supply low
    POWER_RST_O  <= power_rst;
    // R07 system reset excludes backup and debug
    SYSTEM_RST_O <= power_rst | (stretch_ff != 8'h00) | sys_start;
    BACKUP_RST_O <= BACKUP_RST_REQ_I;
    PM_STATE_O   <= power_rst ? 2'(PM_RUN) : 2'(nxt_state);
  end

  // --------------------------------------------------------------------------
  // Low-voltage warning and boot source
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (power_rst) begin
      LVD_IRQ_O <= 1'b0;
    end else begin
      // R09 warning pulse on threshold crossing
      LVD_IRQ_O <= lvd_rise;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYSTEM_RST_O) begin
      boot_done_ff <= 1'b0;
    end else begin
      boot_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (power_rst) begin
      BOOT_SRC_O <= BOOT_FLASH;
    // R10 R11 latch boot choice at release
    end else if (!SYSTEM_RST_O && !boot_done_ff) begin
      BOOT_SRC_O <= boot_decode(BOOT_PINS_I);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_sleep_core_only;
    @(posedge CLK_I) disable iff (power_rst)
      state_ff == PM_SLEEP |-> !CORE_CLK_EN_O && PERIPH_CLK_EN_O;
  endproperty
  a_sleep_core_only: assert property (p_sleep_core_only) else $error("sleep gates periphs"); // R01

  property p_deep_clocks_off;
    @(posedge CLK_I) disable iff (power_rst)
      (state_ff == PM_DEEP && $past(state_ff) == PM_DEEP) |->
        !FAST_RC_EN_O && !CRYSTAL_EN_O && !PLL_EN_O && RETAIN_O;
  endproperty
  a_deep_clocks_off: assert property (p_deep_clocks_off) else $error("deep clocks on"); // R02

  property p_deep_wake;
    @(posedge CLK_I) disable iff (power_rst)
      (state_ff == PM_DEEP && deep_wake) |=> state_ff == PM_RUN;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("deep wake missed"); // R03

  property p_deep_exit_rc;
    @(posedge CLK_I) disable iff (power_rst)
      (state_ff == PM_DEEP && deep_wake) |=> SYS_CLK_SRC_O == `CLK_SRC_FAST_RC;
  endproperty
  a_deep_exit_rc: assert property (p_deep_exit_rc) else $error("deep exit not fast RC"); // R04

  property p_standby_off;
    @(posedge CLK_I) disable iff (power_rst)
      state_ff == PM_STANDBY |-> !CORE_PWR_EN_O && !REGULATOR_EN_O;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("standby powered"); // R05

  property p_standby_stay;
    @(posedge CLK_I) disable iff (power_rst)
      (state_ff == PM_STANDBY && !stby_wake) |=> state_ff == PM_STANDBY;
  endproperty
  a_standby_stay: assert property (p_standby_stay) else $error("standby left"); // R06

  property p_sys_rst;
    @(posedge CLK_I) disable iff (power_rst)
      sys_cause |=> SYSTEM_RST_O ##1 SYSTEM_RST_O;
  endproperty
  a_sys_rst: assert property (p_sys_rst) else $error("system reset missing"); // R07

  property p_supply_hold;
    @(posedge CLK_I) SUPPLY_LOW_I |=> POWER_RST_O && SYSTEM_RST_O;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("no reset on low supply"); // R08

  property p_lvd_irq;
    @(posedge CLK_I) disable iff (power_rst)
      lvd_rise |=> LVD_IRQ_O;
  endproperty
  a_lvd_irq: assert property (p_lvd_irq) else $error("lvd irq missing"); // R09

  property p_boot_hold;
    @(posedge CLK_I) disable iff (power_rst)
      (boot_done_ff && $past(boot_done_ff)) |-> $stable(BOOT_SRC_O);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot source moved"); // R11

endmodule // lpm_rst_ctrl

/* File: lpm_core_model.sv */
/*
  Model of the processor core and the wake sources facing the controller.
  Assumes the bench pulses go_i for one cycle with mode_i and src_i set.
*/
`timescale 1ns/100ps
module lpm_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  state_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [3:0]  src_i,
  input  wire logic        go_i,
  output logic      [2:0]  req_o,
  output logic      [10:0] wake_o
);
  // --------------------------------------------------------------------------
  // Request, wait, wake, done
  // --------------------------------------------------------------------------
  logic [1:0] ph_ff;
  logic [3:0] cnt_ff;

  // Request held until taken; wake held until the core is running again
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ph_ff <= 2'h0;
    else if (go_i)
      ph_ff <= 2'h1;
    else if (ph_ff == 2'h1 && state_i != 2'h0)
      ph_ff <= 2'h2;
    else if (ph_ff == 2'h2 && cnt_ff == 4'h8)
      ph_ff <= 2'h3;
    else if (ph_ff == 2'h3 && state_i == 2'h0)
      ph_ff <= 2'h0;
    cnt_ff <= (ph_ff == 2'h2) ? cnt_ff + 4'h1 : 4'h0;
  end

  assign req_o  = (ph_ff == 2'h1) ? (3'h1 << (mode_i - 2'h1)) : 3'h0;
  assign wake_o = (ph_ff == 2'h3) ? (11'h001 << src_i) : 11'h000;
endmodule // lpm_core_model

/* File: low_power_mode_and_reset_ctrl_tb.sv */
/*
  Self-checking bench for the low-power mode and reset controller.
  Assumes the package, the controller and the core model are compiled first.
*/
`timescale 1ns/100ps
module low_power_mode_and_reset_ctrl_tb;
  import lpm_rst_pkg::*;
  // Short stretch keeps the system reset windows quick to count
  localparam int STR = 4;
  localparam logic [1:0] BMAP [4] = '{BOOT_FLASH, BOOT_SYSMEM, BOOT_FLASH, BOOT_SRAM};
  localparam logic [3:0] SBY [4] = '{4'h8, 4'h3, 4'h9, 4'ha};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0;
  logic        sw_rst = 1'b0;
  logic        bk_rst = 1'b0;
  logic        sup_low = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  src = 4'h0;
  logic [1:0]  clk_sel = 2'h2;
  logic [1:0]  boot = 2'h0;
  logic [10:0] xw = 11'h000;
  logic [2:0]  req;
  logic [10:0] wk;
  logic [10:0] w;
  logic [7:0]  en;
  logic        core_en, per_en, rc_en, xt_en, pll_en, pwr_en, reg_en, retain;
  logic        por, sysr, bkr, lvd_irq;
  logic [1:0]  src_o, boot_o, pm;
  int          n_mismatch = 0;
  int          check_count = 0;

  assign w  = wk | xw;
  assign en = {core_en, per_en, rc_en, xt_en, pll_en, pwr_en, reg_en, retain};

  always #5 clk = ~clk;

  lpm_core_model core (.clk_i(clk), .rst_i(rst), .state_i(pm), .mode_i(mode), .src_i(src),
    .go_i(go), .req_o(req), .wake_o(wk));

  lpm_rst_ctrl #(.STRETCH(STR)) dut (.CLK_I(clk), .RST_I(rst), .SLEEP_REQ_I(req[0]),
    .DEEP_REQ_I(req[1]), .STANDBY_REQ_I(req[2]), .CLK_SEL_I(clk_sel), .IRQ_PENDING_I(w[0]),
    .EVENT_I(w[1]), .PIN_LINES_I(w[2] ? 16'h8000 : 16'h0000), .RTC_ALARM_I(w[3]),
    .RTC_TAMPER_I(w[4]), .SERIAL_WAKE_I(w[5]), .CEC_WAKE_I(w[6]), .LVD_OUT_I(w[7]),
    .SUPPLY_LOW_I(sup_low), .EXT_RESET_PIN_I(w[8]), .WATCHDOG_RST_I(w[9]), .WAKE_PIN_I(w[10]),
    .BACKUP_RST_REQ_I(bk_rst), .SW_RST_REQ_I(sw_rst), .BOOT_PINS_I(boot),
    .CORE_CLK_EN_O(core_en), .PERIPH_CLK_EN_O(per_en), .FAST_RC_EN_O(rc_en),
    .CRYSTAL_EN_O(xt_en), .PLL_EN_O(pll_en), .SYS_CLK_SRC_O(src_o), .CORE_PWR_EN_O(pwr_en),
    .REGULATOR_EN_O(reg_en), .RETAIN_O(retain), .POWER_RST_O(por), .SYSTEM_RST_O(sysr),
    .BACKUP_RST_O(bkr), .LVD_IRQ_O(lvd_irq), .BOOT_SRC_O(boot_o), .PM_STATE_O(pm));

  // --------------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------------
  task final_report;
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sel high waits on the mode, low on the system reset
  task wait_for(input logic sel, input logic [1:0] v);
    int i;
    for (i = 0; i < 40 && (sel ? pm : {1'b0, sysr}) !== v; i++)
      @(negedge clk);
    if ((sel ? pm : {1'b0, sysr}) !== v) begin
      n_mismatch++;
      $display("ERROR t=%0t wait timeout got=%h exp=%h", $time, (sel ? pm : {1'b0, sysr}), v);
      final_report();
    end
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task do_reset;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    chk({por, sysr, pm}, 8'h0c);
    chk(en, 8'he6);
    rst = 1'b0;
    wait_for(1'b0, 2'h0);
    @(negedge clk);
  endtask

  task boot_case(input logic [1:0] pins, input logic [1:0] exp);
    boot = pins;
    do_reset();
    @(negedge clk);
    chk(boot_o, exp);
    boot = ~pins;
    repeat (3) @(negedge clk);
    chk(boot_o, exp);
  endtask

  // Standby also gets every non-waking source thrown at it first
  task run_mode(input logic [1:0] m, input logic [3:0] s, input logic [7:0] exp_en,
                input logic [1:0] exp_src);
    mode = m;
    src = s;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    wait_for(1'b1, m);
    @(negedge clk);
    chk(en, exp_en);
    if (m == 2'h3) begin
      xw = 11'h0f7;
      repeat (3) @(negedge clk);
      chk(pm, m);
      xw = 11'h000;
    end
    wait_for(1'b1, 2'h0);
    if (m == 2'h3)
      chk(sysr, 1'b1);
    else
      chk(src_o, exp_src);
    wait_for(1'b0, 2'h0);
    @(negedge clk);
  endtask

  task sys_reset;
    int   n;
    logic side;
    n = 0;
    side = 1'b0;
    sw_rst = 1'b1;
    @(negedge clk);
    sw_rst = 1'b0;
    repeat (10) begin
      n += (sysr === 1'b1);
      side |= por | bkr;
      @(negedge clk);
    end
    // Cause cycle plus the stretch window
    chk(n[7:0], 8'(STR + 1));
    chk(side, 1'b0);
    bk_rst = 1'b1;
    @(negedge clk);
    chk({por, sysr, bkr}, 8'h01);
    bk_rst = 1'b0;
    @(negedge clk);
  endtask

  task supply_low;
    sup_low = 1'b1;
    repeat (6) @(negedge clk);
    chk({por, sysr}, 8'h03);
    sup_low = 1'b0;
    wait_for(1'b0, 2'h0);
    @(negedge clk);
  endtask

  // Level held high must still give a single warning
  task lvd_pulse;
    int n;
    n = 0;
    xw = 11'h080;
    repeat (6) begin
      @(negedge clk);
      n += (lvd_irq === 1'b1);
    end
    xw = 11'h000;
    chk(n[7:0], 8'h01);
  endtask

  initial begin
    for (int k = 0; k < 4; k++)
      boot_case(k[1:0], BMAP[k]);
    boot = 2'h0;
    run_mode(2'h1, 4'h0, 8'h6e, 2'h2);
    clk_sel = 2'h1;
    run_mode(2'h1, 4'h1, 8'h76, 2'h1);
    clk_sel = 2'h2;
    for (int k = 0; k < 8; k++)
      if (k != 1)
        run_mode(2'h2, k[3:0], 8'h07, 2'h0);
    foreach (SBY[k])
      run_mode(2'h3, SBY[k], 8'h00, 2'h0);
    sys_reset();
    supply_low();
    lvd_pulse();
    final_report();
  end
endmodule // low_power_mode_and_reset_ctrl_tb
